// ---- rtl/saip_pkg.sv ----
package saip_pkg;

  // ------------------------------------------------------------
  // Clocking and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned HALT_TIME_NS  = 5_000;     // Silence that counts as halt
  localparam int unsigned HALT_CYC      = (HALT_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned GOOD_FRAMES   = 2;         // Clean frames before play

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] FORMAT_CONTROL_ADDR     = 8'h33;
  localparam logic [7:0] DATA_OFFSET_LOW_ADDR    = 8'h34;
  localparam logic [7:0] CLOCK_FAULT_STATUS_ADDR = 8'h71;

  // ------------------------------------------------------------
  // Format control fields and reset values
  // ------------------------------------------------------------
  localparam int unsigned FMT_OFFSET_MSB_POS = 7;
  localparam int unsigned FMT_MODE_LSB       = 4;
  localparam int unsigned FMT_SYNC_LSB       = 2;
  localparam int unsigned FMT_WLEN_LSB       = 0;
  localparam logic [7:0]  FORMAT_CONTROL_RST  = 8'h02;  // I2S, 24-bit
  localparam logic [7:0]  DATA_OFFSET_LOW_RST = 8'h00;
  localparam logic [1:0]  SYNC_SHORT          = 2'h1;

  // Status fields
  localparam int unsigned STS_CLK_ERR_POS   = 0;
  localparam int unsigned STS_RATE_LSB      = 2;
  localparam int unsigned STS_RATE_UNK_POS  = 4;
  localparam int unsigned STS_RATIO_BAD_POS = 5;
  localparam int unsigned STS_HALT_POS      = 6;

  // ------------------------------------------------------------
  // Enumerations
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SAIP_FMT_I2S = 2'h0,
    SAIP_FMT_TDM = 2'h1,
    SAIP_FMT_RJ  = 2'h2,
    SAIP_FMT_LJ  = 2'h3
  } saip_fmt_t;

  typedef enum logic [1:0] {
    SAIP_RATE_32K  = 2'h0,
    SAIP_RATE_48K  = 2'h1,
    SAIP_RATE_96K  = 2'h2,
    SAIP_RATE_192K = 2'h3
  } saip_rate_t;

  typedef enum logic [1:0] {
    SAIP_ST_SLEEP = 2'b01,
    SAIP_ST_PLAY  = 2'b10
  } saip_state_t;

  // ------------------------------------------------------------
  // Rate windows, frame period in cycles (+-5 %)
  // ------------------------------------------------------------
  localparam int unsigned R32_MIN  = CLK_HZ / 33_600;
  localparam int unsigned R32_MAX  = CLK_HZ / 30_400;
  localparam int unsigned R48_MIN  = CLK_HZ / 50_400;
  localparam int unsigned R48_MAX  = CLK_HZ / 41_895;
  localparam int unsigned R96_MIN  = CLK_HZ / 100_800;
  localparam int unsigned R96_MAX  = CLK_HZ / 83_790;
  localparam int unsigned R192_MIN = CLK_HZ / 201_600;
  localparam int unsigned R192_MAX = CLK_HZ / 167_580;

  // Bit clock to word clock ratios
  localparam logic [9:0] RATIO_32  = 10'h020;
  localparam logic [9:0] RATIO_64  = 10'h040;
  localparam logic [9:0] RATIO_128 = 10'h080;
  localparam logic [9:0] RATIO_256 = 10'h100;
  localparam logic [9:0] RATIO_512 = 10'h200;
  localparam logic [9:0] CNT_SAT   = 10'h3FF;

endpackage

// ---- rtl/saip_sync.sv ----
`timescale 1ns/1ps

// --------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// --------------------------------------------------------------
module saip_sync #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_next;

  // Only the second stage reads the first
  always_comb begin
    meta_next = srst ? '0 : async_in;
    sync_next = srst ? '0 : meta_reg;
  end

  always_ff @(posedge ref_clk) begin
    meta_reg <= meta_next;
    sync_out <= sync_next;
  end

endmodule // saip_sync

// ---- rtl/saip_port.sv ----
`timescale 1ns/1ps

// Operation
// R1 - Shift each serial data bit in on the bit clock rising edge.
// R2 - Derive processing clock ticks from the incoming bit clock alone.
// R3 - Measure frame period and classify 32, 48, 96 or 192 kHz family.
// R4 - On clock stop sleep and tri-state outputs; resume play automatically.
// R5 - Flag clock error in status at 0x71 on halt or bad ratio.
// R6 - Non-TDM formats need bit clock of 32 or 64 times word rate.
// R7 - TDM ratios 128/256/512 allowed depending on detected sample rate.
// R8 - Host halts clocks 100 us before changing sample rate.
// R9 - Format chosen by format control bits 5 to 4.
// R10 - Software sets sync field to 01 for short TDM sync pulses.
// R11 - Samples are two's complement, MSB first, up to 32 bits.
// R12 - Word length taken from format control bits 1 to 0.
// R13 - Nine-bit data offset from format bit 7 and offset register.
// R14 - Reset configuration is I2S framing with 24-bit words.
// R15 - I2S: word clock low is left, high is right.
// R16 - Right-justified: word clock high is left, low is right.
// R17 - TDM frame starts at frame sync rising edge.
// R18 - Clock error derives only from synchronised, registered signals.
module saip_port (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        bit_clock,
  input  wire logic        word_select_frame_sync,
  input  wire logic        serial_data_in,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic      [31:0] left_sample,
  output logic      [31:0] right_sample,
  output logic             sample_valid,
  output logic             proc_tick,
  output logic             proc_sleep,
  output logic             output_hiz,
  output logic             clock_error,
  output logic      [1:0]  rate_code
);

  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------
  logic [2:0] pins_sync;
  logic       sck_s;
  logic       ws_s;
  logic       sd_s;

  saip_sync #(
    .WIDTH (3)
  ) u_sync (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .async_in ({bit_clock, word_select_frame_sync, serial_data_in}),
    .sync_out (pins_sync)
  );  // see R18

  assign sck_s = pins_sync[2];
  assign ws_s  = pins_sync[1];
  assign sd_s  = pins_sync[0];

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [7:0] format_control_reg;
  logic [7:0] format_control_next;
  logic [7:0] data_offset_low_reg;
  logic [7:0] data_offset_low_next;
  logic [7:0] rdata_next;
  logic [7:0] status;

  saip_pkg::saip_fmt_t fmt;
  logic [1:0]          sync_mode;
  logic [5:0]          wlen;
  logic [9:0]          offset;

  // Field decode
  always_comb begin
    fmt       = saip_pkg::saip_fmt_t'(format_control_reg[saip_pkg::FMT_MODE_LSB +: 2]);  // see R9
    sync_mode = format_control_reg[saip_pkg::FMT_SYNC_LSB +: 2];  // see R10
    case (format_control_reg[saip_pkg::FMT_WLEN_LSB +: 2])  // see R12
      2'h0:    wlen = 6'h10;
      2'h1:    wlen = 6'h14;
      2'h2:    wlen = 6'h18;
      default: wlen = 6'h20;
    endcase
    offset = {1'b0, format_control_reg[saip_pkg::FMT_OFFSET_MSB_POS], data_offset_low_reg};  // see R13
  end

  // Writes and registered read data; unmapped reads return zero
  always_comb begin
    format_control_next  = format_control_reg;
    data_offset_low_next = data_offset_low_reg;
    rdata_next           = reg_rdata;
    if (reg_wr && reg_addr == saip_pkg::FORMAT_CONTROL_ADDR) begin
      format_control_next = reg_wdata;
    end
    if (reg_wr && reg_addr == saip_pkg::DATA_OFFSET_LOW_ADDR) begin
      data_offset_low_next = reg_wdata;
    end
    if (reg_rd) begin
      case (reg_addr)
        saip_pkg::FORMAT_CONTROL_ADDR:     rdata_next = format_control_reg;
        saip_pkg::DATA_OFFSET_LOW_ADDR:    rdata_next = data_offset_low_reg;
        saip_pkg::CLOCK_FAULT_STATUS_ADDR: rdata_next = status;  // see R5
        default:                           rdata_next = 8'h00;
      endcase
    end
    if (srst) begin
      format_control_next  = saip_pkg::FORMAT_CONTROL_RST;  // see R14
      data_offset_low_next = saip_pkg::DATA_OFFSET_LOW_RST;
      rdata_next           = 8'h00;
    end
  end

  always_ff @(posedge ref_clk) begin
    format_control_reg  <= format_control_next;
    data_offset_low_reg <= data_offset_low_next;
    reg_rdata           <= rdata_next;
  end

  // ------------------------------------------------------------
  // Receive path
  // ------------------------------------------------------------
  logic        sck_prev_reg;
  logic        ws_prev_reg;
  logic [9:0]  bit_cnt_reg;
  logic [9:0]  bit_cnt_next;
  logic [31:0] shift_reg;
  logic [31:0] shift_next;
  logic [31:0] cap_a_reg;
  logic [31:0] cap_a_next;
  logic [31:0] cap_b_reg;
  logic [31:0] cap_b_next;
  logic [31:0] left_next;
  logic [31:0] right_next;
  logic        valid_next;
  logic        tick_next;
  logic        sck_rise;
  logic        ws_edge;
  logic        frame_start;
  logic [9:0]  cur;
  logic [9:0]  start;
  logic [9:0]  idx_a;
  logic [9:0]  idx_b;
  logic        prev_left;
  logic [31:0] rj_word;

  assign sck_rise    = sck_s && !sck_prev_reg;
  assign ws_edge     = ws_s != ws_prev_reg;
  assign frame_start = ws_s && !ws_prev_reg;

  always_comb begin
    bit_cnt_next = bit_cnt_reg;
    shift_next   = shift_reg;
    cap_a_next   = cap_a_reg;
    cap_b_next   = cap_b_reg;
    left_next    = left_sample;
    right_next   = right_sample;
    valid_next   = 1'b0;
    tick_next    = 1'b0;
    cur          = 10'h000;
    start        = offset;
    idx_a        = 10'h000;
    idx_b        = 10'h000;
    // Half that just ended was left: I2S low is left, RJ/LJ high is left
    prev_left    = (fmt == saip_pkg::SAIP_FMT_I2S) ? !ws_prev_reg : ws_prev_reg;  // see R15 R16
    rj_word      = shift_reg << (6'h20 - wlen);  // RJ: last bits before the edge
    if (sck_rise) begin
      tick_next  = 1'b1;  // see R2
      shift_next = {shift_reg[30:0], sd_s};  // see R1
      if (fmt == saip_pkg::SAIP_FMT_TDM) begin
        cur = frame_start ? 10'h000 : ((bit_cnt_reg == saip_pkg::CNT_SAT) ? bit_cnt_reg : bit_cnt_reg + 10'h001);
        if (sync_mode == saip_pkg::SYNC_SHORT) begin
          start = offset + 10'h001;  // Short sync: MSB follows the pulse
        end
        if (frame_start) begin  // see R17
          left_next  = cap_a_reg;
          right_next = cap_b_reg;
          valid_next = 1'b1;
          cap_a_next = 32'h0000_0000;
          cap_b_next = 32'h0000_0000;
        end
      end else begin
        cur = ws_edge ? 10'h000 : ((bit_cnt_reg == saip_pkg::CNT_SAT) ? bit_cnt_reg : bit_cnt_reg + 10'h001);
        if (fmt == saip_pkg::SAIP_FMT_I2S) begin
          start = offset + 10'h001;  // I2S one-bit delay
        end
        if (ws_edge) begin
          if (prev_left) begin
            left_next  = (fmt == saip_pkg::SAIP_FMT_RJ) ? rj_word : cap_a_reg;
          end else begin
            right_next = (fmt == saip_pkg::SAIP_FMT_RJ) ? rj_word : cap_a_reg;
            valid_next = 1'b1;  // Pair complete after right half
          end
          cap_a_next = 32'h0000_0000;
        end
      end
      bit_cnt_next = cur;
      idx_a        = cur - start;
      idx_b        = cur - start - {4'h0, wlen};
      // MSB first, left aligned, sign kept
      if (cur >= start && idx_a < {4'h0, wlen}) begin
        cap_a_next[5'd31 - idx_a[4:0]] = sd_s;  // see R11
      end else if (fmt == saip_pkg::SAIP_FMT_TDM && cur >= start + {4'h0, wlen} && idx_b < {4'h0, wlen}) begin
        cap_b_next[5'd31 - idx_b[4:0]] = sd_s;
      end
    end
    if (srst) begin
      bit_cnt_next = 10'h000;
      shift_next   = 32'h0000_0000;
      cap_a_next   = 32'h0000_0000;
      cap_b_next   = 32'h0000_0000;
      left_next    = 32'h0000_0000;
      right_next   = 32'h0000_0000;
      valid_next   = 1'b0;
      tick_next    = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    bit_cnt_reg  <= bit_cnt_next;
    shift_reg    <= shift_next;
    cap_a_reg    <= cap_a_next;
    cap_b_reg    <= cap_b_next;
    left_sample  <= left_next;
    right_sample <= right_next;
    sample_valid <= valid_next;
    proc_tick    <= tick_next;
  end

  // ------------------------------------------------------------
  // Clock supervision
  // ------------------------------------------------------------
  logic [11:0] idle_cnt_reg;
  logic [11:0] idle_cnt_next;
  logic [9:0]  ratio_cnt_reg;
  logic [9:0]  ratio_cnt_next;
  logic [11:0] period_cnt_reg;
  logic [11:0] period_cnt_next;
  logic        halt_reg;
  logic        halt_next;
  logic        ratio_bad_reg;
  logic        ratio_bad_next;
  logic        rate_unk_reg;
  logic        rate_unk_next;
  logic [1:0]  rate_next;
  logic [1:0]  good_reg;
  logic [1:0]  good_next;
  logic        ws_prev_next;
  logic        sck_prev_next;
  logic        ratio_ok;
  logic [9:0]  ratio_meas;

  always_comb begin
    ratio_meas = ratio_cnt_reg + 10'h001;
    ratio_ok   = 1'b0;
    if (fmt == saip_pkg::SAIP_FMT_TDM) begin  // see R7
      ratio_ok = ratio_meas == saip_pkg::RATIO_128;
      if (rate_unk_reg || rate_code == saip_pkg::SAIP_RATE_48K || rate_code == saip_pkg::SAIP_RATE_96K) begin
        ratio_ok = ratio_ok || ratio_meas == saip_pkg::RATIO_256;
      end
      if (rate_unk_reg || rate_code == saip_pkg::SAIP_RATE_48K) begin
        ratio_ok = ratio_ok || ratio_meas == saip_pkg::RATIO_512;
      end
    end else begin
      ratio_ok = ratio_meas == saip_pkg::RATIO_32 || ratio_meas == saip_pkg::RATIO_64;  // see R6
    end
  end

  always_comb begin
    sck_prev_next   = sck_s;
    ws_prev_next    = sck_rise ? ws_s : ws_prev_reg;
    idle_cnt_next   = sck_rise ? 12'h000 : ((idle_cnt_reg == 12'hFFF) ? idle_cnt_reg : idle_cnt_reg + 12'h001);
    halt_next       = idle_cnt_reg >= 12'(saip_pkg::HALT_CYC);  // see R4
    period_cnt_next = (period_cnt_reg == 12'hFFF) ? period_cnt_reg : period_cnt_reg + 12'h001;
    ratio_cnt_next  = ratio_cnt_reg;
    ratio_bad_next  = ratio_bad_reg;
    rate_unk_next   = rate_unk_reg;
    rate_next       = rate_code;
    good_next       = good_reg;
    if (sck_rise) begin
      ratio_cnt_next = (ratio_cnt_reg == saip_pkg::CNT_SAT) ? ratio_cnt_reg : ratio_cnt_reg + 10'h001;
      if (ratio_cnt_reg == saip_pkg::CNT_SAT) begin
        ratio_bad_next = 1'b1;  // Word clock stopped while bit clock runs
        good_next      = 2'h0;
      end
      if (frame_start) begin
        ratio_cnt_next  = 10'h000;
        period_cnt_next = 12'h000;
        ratio_bad_next  = !ratio_ok;  // see R5
        good_next       = !ratio_ok ? 2'h0 : ((good_reg == 2'h3) ? good_reg : good_reg + 2'h1);
        rate_unk_next   = 1'b0;
        // Frame period picks the rate family
        if (period_cnt_reg >= 12'(saip_pkg::R32_MIN) && period_cnt_reg <= 12'(saip_pkg::R32_MAX)) begin  // see R3
          rate_next = saip_pkg::SAIP_RATE_32K;
        end else if (period_cnt_reg >= 12'(saip_pkg::R48_MIN) && period_cnt_reg <= 12'(saip_pkg::R48_MAX)) begin
          rate_next = saip_pkg::SAIP_RATE_48K;
        end else if (period_cnt_reg >= 12'(saip_pkg::R96_MIN) && period_cnt_reg <= 12'(saip_pkg::R96_MAX)) begin
          rate_next = saip_pkg::SAIP_RATE_96K;
        end else if (period_cnt_reg >= 12'(saip_pkg::R192_MIN) && period_cnt_reg <= 12'(saip_pkg::R192_MAX)) begin
          rate_next = saip_pkg::SAIP_RATE_192K;
        end else begin
          rate_unk_next = 1'b1;
        end
      end
    end
    if (halt_reg) begin
      good_next = 2'h0;
    end
    if (srst) begin
      sck_prev_next   = 1'b0;
      ws_prev_next    = 1'b0;
      idle_cnt_next   = 12'hFFF;  // Counts as silent, so halt holds until a clock arrives
      halt_next       = 1'b1;  // No clocks seen yet
      period_cnt_next = 12'h000;
      ratio_cnt_next  = 10'h000;
      ratio_bad_next  = 1'b0;
      rate_unk_next   = 1'b1;
      rate_next       = saip_pkg::SAIP_RATE_48K;
      good_next       = 2'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    sck_prev_reg   <= sck_prev_next;
    ws_prev_reg    <= ws_prev_next;
    idle_cnt_reg   <= idle_cnt_next;
    halt_reg       <= halt_next;
    period_cnt_reg <= period_cnt_next;
    ratio_cnt_reg  <= ratio_cnt_next;
    ratio_bad_reg  <= ratio_bad_next;
    rate_unk_reg   <= rate_unk_next;
    rate_code      <= rate_next;
    good_reg       <= good_next;
  end

  // ------------------------------------------------------------
  // Play / sleep control
  // ------------------------------------------------------------
  saip_pkg::saip_state_t state_reg;
  saip_pkg::saip_state_t state_next;
  logic                  err_next;

  // Config untouched, so play resumes as before
  always_comb begin
    err_next   = halt_reg || ratio_bad_reg;  // see R5 R18
    state_next = state_reg;
    case (state_reg)
      saip_pkg::SAIP_ST_PLAY: begin
        if (err_next) begin
          state_next = saip_pkg::SAIP_ST_SLEEP;  // see R4
        end
      end
      saip_pkg::SAIP_ST_SLEEP: begin
        if (!err_next && good_reg >= 2'(saip_pkg::GOOD_FRAMES)) begin
          state_next = saip_pkg::SAIP_ST_PLAY;  // see R4
        end
      end
      default: state_next = saip_pkg::SAIP_ST_SLEEP;
    endcase
    if (srst) begin
      state_next = saip_pkg::SAIP_ST_SLEEP;
      err_next   = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    state_reg   <= state_next;
    clock_error <= err_next;
    proc_sleep  <= state_next == saip_pkg::SAIP_ST_SLEEP;
    output_hiz  <= state_next == saip_pkg::SAIP_ST_SLEEP;
  end

  // Fault register word
  always_comb begin
    status = 8'h00;
    status[saip_pkg::STS_CLK_ERR_POS]         = clock_error;
    status[saip_pkg::STS_RATE_LSB +: 2]       = rate_code;
    status[saip_pkg::STS_RATE_UNK_POS]        = rate_unk_reg;
    status[saip_pkg::STS_RATIO_BAD_POS]       = ratio_bad_reg;
    status[saip_pkg::STS_HALT_POS]            = halt_reg;
  end

endmodule // saip_port

// ---- dv/saip_port_asserts.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------
// Port checks
// ----------------------------------------------------------
module saip_port_asserts (
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic        bit_clock,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [31:0] right_sample,
  input wire logic        sample_valid,
  input wire logic        proc_tick,
  input wire logic        proc_sleep,
  input wire logic        output_hiz,
  input wire logic        clock_error
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  logic [7:0] idle_reg;
  logic [7:0] idle_next;
  logic       pin_reg;
  logic       pin_next;

  // Cycles since the pin moved, saturating
  always_comb begin
    pin_next  = bit_clock;
    idle_next = (srst || bit_clock != pin_reg) ? 8'h00 : idle_reg + {7'h00, idle_reg != 8'hFF};
  end

  always_ff @(posedge ref_clk) begin
    pin_reg  <= pin_next;
    idle_reg <= idle_next;
  end

  // Ten spare cycles cover the synchroniser
  AST_HALT_FLAGGED: assert property (idle_reg > 8'h6E |-> clock_error)
    else $error("halt not flagged");
  AST_STATUS_ERR: assert property (reg_rd && reg_addr == 8'h71 && clock_error && $past(clock_error)
    |=> reg_rdata[0] && !reg_rdata[7])
    else $error("status misses error");
  AST_ERR_SLEEPS: assert property (clock_error |=> proc_sleep)
    else $error("error without sleep");
  AST_HIZ_IS_SLEEP: assert property (output_hiz == proc_sleep)
    else $error("hiz and sleep differ");
  AST_TICK_ON_EDGE: assert property ($rose(bit_clock) |-> ##[1:5] proc_tick)
    else $error("no tick after edge");
  AST_TICK_PULSE: assert property (proc_tick |=> !proc_tick)
    else $error("tick too long");
  AST_VALID_PULSE: assert property (sample_valid |=> !sample_valid [*2])
    else $error("valid too long");
  AST_RIGHT_ON_VALID: assert property (!$stable(right_sample) |-> sample_valid)
    else $error("right moved without valid");
  AST_RDATA_HOLDS: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("rdata moved without read");
  AST_UNMAPPED_ZERO: assert property (reg_rd && !(reg_addr inside {8'h33, 8'h34, 8'h71})
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule // saip_port_asserts

bind saip_port saip_port_asserts u_asserts (.ref_clk, .srst, .bit_clock, .reg_addr, .reg_rd, .reg_rdata,
  .right_sample, .sample_valid, .proc_tick, .proc_sleep, .output_hiz, .clock_error);

// ---- dv/saip_host_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------
// Audio host: framed clocks, 400 ns bit
// ----------------------------------------------------------
module saip_host_model (
  input  wire logic                run,
  input  wire saip_pkg::saip_fmt_t fmt,
  input  wire logic [5:0]          wlen,
  input  wire logic [9:0]          ratio,
  input  wire logic [8:0]          ofs,
  input  wire logic [31:0]         left_word,
  input  wire logic [31:0]         right_word,
  output logic                     bit_clock,
  output logic                     word_select_frame_sync,
  output logic                     serial_data_in
);
  // Whole frames; clock parked low between runs
  initial begin
    int          half;
    int          idx;
    logic [31:0] w;
    bit_clock = 1'b0;
    word_select_frame_sync = 1'b0;
    serial_data_in = 1'b0;
    forever begin
      wait (run);
      #13;
      half = int'(ratio) / 2;
      for (int i = 0; i < int'(ratio); i++) begin
        w = (i < half) ? left_word : right_word;
        case (fmt)
          saip_pkg::SAIP_FMT_I2S: begin
            word_select_frame_sync = (i >= half);
            idx = i % half - 1 - int'(ofs);
          end
          saip_pkg::SAIP_FMT_RJ: begin
            word_select_frame_sync = (i < half);
            idx = i % half - half + int'(wlen);
          end
          saip_pkg::SAIP_FMT_LJ: begin
            word_select_frame_sync = (i < half);
            idx = i % half - int'(ofs);
          end
          default: begin
            // One-bit sync pulse needs short sync
            word_select_frame_sync = (i == 0);
            idx = i - 1 - int'(ofs);
            w = (idx < int'(wlen)) ? left_word : right_word;
            idx = (idx < int'(wlen)) ? idx : idx - int'(wlen);
          end
        endcase
        // MSB first; idle bits toggle to expose stray sampling
        serial_data_in = (idx >= 0 && idx < int'(wlen)) ? w[31 - idx] : i[0];
        #200 bit_clock = 1'b1;
        #200 bit_clock = 1'b0;
      end
      if (!run) serial_data_in = ~serial_data_in;
    end
  end
endmodule // saip_host_model

// ---- dv/tb_saip_port.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------
// Bench: registers and host audio frames
// ----------------------------------------------------------
module tb_saip_port;
  logic                ref_clk;
  logic                srst;
  logic                bit_clock;
  logic                word_select_frame_sync;
  logic                serial_data_in;
  logic [7:0]          reg_addr;
  logic                reg_wr;
  logic [7:0]          reg_wdata;
  logic                reg_rd;
  logic [7:0]          reg_rdata;
  logic [31:0]         left_sample;
  logic [31:0]         right_sample;
  logic                sample_valid;
  logic                proc_tick;
  logic                proc_sleep;
  logic                output_hiz;
  logic                clock_error;
  logic [1:0]          rate_code;
  logic                run;
  saip_pkg::saip_fmt_t fmt;
  logic [5:0]          wlen;
  logic [9:0]          ratio;
  logic [8:0]          ofs;
  logic [7:0]          rv;
  int                  fail_count = 0;
  int                  n_compared = 0;
  int                  cyc = 0;
  localparam logic [31:0] LEFT_W  = 32'h9ABCDEF1;
  localparam logic [31:0] RIGHT_W = 32'h13579BDF;

  saip_port dut (.ref_clk, .srst, .bit_clock, .word_select_frame_sync, .serial_data_in, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rdata, .left_sample, .right_sample, .sample_valid, .proc_tick, .proc_sleep,
    .output_hiz, .clock_error, .rate_code);
  saip_host_model host (.run, .fmt, .wlen, .ratio, .ofs, .left_word(LEFT_W), .right_word(RIGHT_W),
    .bit_clock, .word_select_frame_sync, .serial_data_in);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Ceiling covers the 512-bit frames
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 32'h17318) begin
      fail_count++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask

  // Wait for play (0), valid (1) or error (2)
  task automatic await(input int lim, input int which);
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      #1;
      k++;
    end while (k < lim && !(which == 0 ? output_hiz === 1'b0 : which == 1 ? sample_valid === 1'b1
      : clock_error === 1'b1));
    chk(32'(k < lim), 32'h1);
  endtask

  task automatic run_case(input saip_pkg::saip_fmt_t f, input logic [1:0] wc, input logic [9:0] r,
    input logic [8:0] o, input logic bad);
    int          wl;
    logic [31:0] mask;
    logic [1:0]  sync;
    wl = (wc == 2'h3) ? 32 : 16 + 4 * int'(wc);
    mask = ~(32'hFFFFFFFF >> wl);
    sync = (f == saip_pkg::SAIP_FMT_TDM) ? saip_pkg::SYNC_SHORT : 2'h0;
    run = 1'b0;
    await(8 * int'(ratio) + 200, 2);
    chk(32'(output_hiz), 32'h1);
    rreg(saip_pkg::CLOCK_FAULT_STATUS_ADDR, rv);
    chk(32'(rv & 8'h41), 32'h41);
    repeat (12'h7D0) @(posedge ref_clk);
    wreg(saip_pkg::FORMAT_CONTROL_ADDR, {o[8], 1'b0, f, sync, wc});
    wreg(saip_pkg::DATA_OFFSET_LOW_ADDR, o[7:0]);
    rreg(saip_pkg::FORMAT_CONTROL_ADDR, rv);
    chk(32'(rv), 32'({o[8], 1'b0, f, sync, wc}));
    fmt = f;
    wlen = 6'(wl);
    ratio = r;
    ofs = o;
    run = 1'b1;
    if (bad) begin
      repeat (48 * int'(r)) @(posedge ref_clk);
      rreg(saip_pkg::CLOCK_FAULT_STATUS_ADDR, rv);
      chk(32'(rv & 8'h21), 32'h21);
      chk(32'(output_hiz), 32'h1);
    end else begin
      await(64 * int'(r), 0);
      await(16 * int'(r), 1);
      await(16 * int'(r), 1);
      chk(left_sample, LEFT_W & mask);
      chk(right_sample, RIGHT_W & mask);
      chk(32'(clock_error), 32'h0);
      chk(32'(rate_code), 32'h1);
    end
  endtask

  task automatic summarize();
    $display("compared %0d bad %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    srst = 1'b1;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    run = 1'b0;
    fmt = saip_pkg::SAIP_FMT_I2S;
    wlen = 6'h18;
    ratio = 10'h040;
    ofs = 9'h000;
    repeat (4'h8) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    chk(32'(output_hiz), 32'h1);
    rreg(saip_pkg::FORMAT_CONTROL_ADDR, rv);
    chk(32'(rv), 32'h02);
    // Status and unmapped writes change nothing
    wreg(8'h71, 8'hFF);
    wreg(8'h55, 8'hFF);
    rreg(8'h55, rv);
    chk(32'(rv), 32'h0);
    rreg(saip_pkg::CLOCK_FAULT_STATUS_ADDR, rv);
    chk(32'(rv), 32'h55);
    rreg(saip_pkg::DATA_OFFSET_LOW_ADDR, rv);
    chk(32'(rv), 32'h0);
    run_case(saip_pkg::SAIP_FMT_I2S, 2'h2, 10'h040, 9'h000, 1'b0);
    run_case(saip_pkg::SAIP_FMT_LJ, 2'h0, 10'h020, 9'h000, 1'b0);
    run_case(saip_pkg::SAIP_FMT_RJ, 2'h1, 10'h040, 9'h000, 1'b0);
    run_case(saip_pkg::SAIP_FMT_TDM, 2'h3, 10'h080, 9'h000, 1'b0);
    run_case(saip_pkg::SAIP_FMT_TDM, 2'h0, 10'h200, 9'h104, 1'b0);
    run_case(saip_pkg::SAIP_FMT_LJ, 2'h2, 10'h040, 9'h005, 1'b0);
    run_case(saip_pkg::SAIP_FMT_I2S, 2'h3, 10'h080, 9'h000, 1'b1);
    summarize();
  end
endmodule // tb_saip_port
